// ===== verilog/uhor_regs.sv
/*
 * Operational register bank of a USB 1.1 host controller: command and
 * status, interrupt flags and enables, list pointers, frame counter.
 * Assumes a single-cycle register port from the bus slave and one-cycle
 * event pulses from the list processor, frame logic and root hub.
 */
`timescale 1ns/1ps
`default_nettype none

module uhor_regs
    import uhor_pkg::*;
(
    input  wire logic             SYS_CLK,
    input  wire logic             RST_N,
    input  wire uhor_pkg::uhor_req_t REQ,
    output logic [31:0]           RDATA,
    input  wire uhor_pkg::uhor_evt_t EVT,
    input  wire logic             FRAME_RELOAD,
    input  wire logic [31:0]      DONE_HEAD_IN,
    input  wire logic             DONE_HEAD_LOAD,
    output logic                  SOFT_RESET_REQ,
    output logic                  CTRL_PENDING,
    output logic                  BULK_PENDING,
    output logic [31:0]           COMM_AREA,
    output logic [31:0]           CTRL_HEAD,
    output logic [31:0]           BULK_HEAD,
    output logic [31:0]           FRAME_LEN,
    output logic [15:0]           FRAME_NUMBER,
    output logic                  IRQ
);
    import uhor_pkg::*;

    function automatic logic hit(input uhor_req_t r, input logic [31:0] a);
        hit = r.sel && r.wr && (r.addr == a);
    endfunction : hit

    uhor_state_t state;
    uhor_state_t next_state;
    logic [31:0] cmd, next_cmd;
    logic [31:0] flags, next_flags;
    logic [31:0] enables, next_enables;
    logic [31:0] comm_area_pointer, next_comm_area_pointer;
    logic [31:0] periodic_cursor, next_periodic_cursor;
    logic [31:0] control_head_ptr, next_control_head_ptr;
    logic [31:0] control_cursor, next_control_cursor;
    logic [31:0] bulk_head_ptr, next_bulk_head_ptr;
    logic [31:0] bulk_cursor, next_bulk_cursor;
    logic [31:0] completed_head_ptr, next_completed_head_ptr;
    logic [31:0] frame_len, next_frame_len;
    logic [15:0] frame_counter, next_frame_counter;
    logic [31:0] next_rdata;
    logic [31:0] set_ev;
    logic [1:0]  ovr_cnt;

    // command and status register
    always_comb begin
        next_cmd   = cmd;
        next_state = state;
        ovr_cnt    = cmd[`UHOR_CNT_HI:`UHOR_CNT_LO];
        if (hit(REQ, `UHOR_OFS_CMD)) begin
            next_cmd[`UHOR_BIT_OWNER_REQ]  = REQ.wdata[`UHOR_BIT_OWNER_REQ];
            next_cmd[`UHOR_BIT_BULK_PEND]  = REQ.wdata[`UHOR_BIT_BULK_PEND];
            next_cmd[`UHOR_BIT_CTRL_PEND]  = REQ.wdata[`UHOR_BIT_CTRL_PEND];
            if (REQ.wdata[`UHOR_BIT_SOFT_RESET]) begin
                next_cmd[`UHOR_BIT_SOFT_RESET] = 1'b1;
            end
        end
        if (EVT.bulk_begin) begin
            next_cmd[`UHOR_BIT_BULK_PEND] = 1'b0;
        end
        if (EVT.bulk_fill) begin
            next_cmd[`UHOR_BIT_BULK_PEND] = 1'b1;
        end
        if (EVT.ctrl_begin) begin
            next_cmd[`UHOR_BIT_CTRL_PEND] = 1'b0;
        end
        if (EVT.ctrl_fill) begin
            next_cmd[`UHOR_BIT_CTRL_PEND] = 1'b1;
        end
        if (EVT.overrun) begin
            next_cmd[`UHOR_CNT_HI:`UHOR_CNT_LO] = 2'(ovr_cnt + 2'h1);
        end
        case (state)
            UHOR_IDLE: begin
                if (next_cmd[`UHOR_BIT_SOFT_RESET]) begin
                    next_state = UHOR_RESET;
                end
            end
            UHOR_RESET: begin
                if (EVT.reset_done) begin
                    next_cmd[`UHOR_BIT_SOFT_RESET] = 1'b0;
                    next_state = UHOR_IDLE;
                end
            end
            default: next_state = UHOR_IDLE;
        endcase
        next_cmd = next_cmd & 32'h0003_000F;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cmd   <= `UHOR_RST_ZERO;
            state <= UHOR_IDLE;
        end else begin
            cmd   <= next_cmd;
            state <= next_state;
        end
    end

    // frame counter and interrupt flags
    always_comb begin
        next_frame_counter = frame_counter;
        if (FRAME_RELOAD) begin
            next_frame_counter = 16'(frame_counter + 16'h0001);
        end
        set_ev = `UHOR_RST_ZERO;
        set_ev[`UHOR_BIT_OVERRUN]      = EVT.overrun;
        set_ev[`UHOR_BIT_DONE_WRITTEN] = EVT.done_written;
        set_ev[`UHOR_BIT_FRAME_START]  = EVT.frame_start;
        set_ev[`UHOR_BIT_RESUME]       = EVT.resume;
        set_ev[`UHOR_BIT_HUB_CHANGE]   = EVT.hub_change;
        set_ev[`UHOR_BIT_FRAME_WRAP]   = next_frame_counter[`UHOR_FRAME_MSB]
                                      ^ frame_counter[`UHOR_FRAME_MSB];
        set_ev[`UHOR_BIT_OWNER_SWAP]   = cmd[`UHOR_BIT_OWNER_REQ];
        next_flags = flags;
        if (hit(REQ, `UHOR_OFS_IRQ_FLAGS)) begin
            next_flags = flags & ~REQ.wdata;
        end
        // set wins over a simultaneous clear; fatal bit stays zero
        next_flags = (next_flags | set_ev) & `UHOR_EVENT_MASK;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            flags         <= `UHOR_RST_ZERO;
            frame_counter <= 16'h0000;
        end else begin
            flags         <= next_flags;
            frame_counter <= next_frame_counter;
        end
    end

    // interrupt enables
    always_comb begin
        next_enables = enables;
        if (hit(REQ, `UHOR_OFS_IRQ_EN_SET)) begin
            next_enables = enables | (REQ.wdata & `UHOR_ENABLE_MASK);
        end
        if (hit(REQ, `UHOR_OFS_IRQ_EN_CLR)) begin
            next_enables = enables & ~(REQ.wdata & `UHOR_ENABLE_MASK);
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            enables <= `UHOR_RST_ZERO;
        end else begin
            enables <= next_enables;
        end
    end

    // pointer registers and frame length
    always_comb begin
        next_comm_area_pointer  = comm_area_pointer;
        next_periodic_cursor    = periodic_cursor;
        next_control_head_ptr   = control_head_ptr;
        next_control_cursor     = control_cursor;
        next_bulk_head_ptr      = bulk_head_ptr;
        next_bulk_cursor        = bulk_cursor;
        next_completed_head_ptr = completed_head_ptr;
        next_frame_len          = frame_len;
        if (hit(REQ, `UHOR_OFS_COMM_AREA)) begin
            next_comm_area_pointer = REQ.wdata & `UHOR_COMM_AREA_MASK;
        end
        if (hit(REQ, `UHOR_OFS_PERIODIC)) begin
            next_periodic_cursor = REQ.wdata & `UHOR_PTR_MASK;
        end
        if (hit(REQ, `UHOR_OFS_CTRL_HEAD)) begin
            next_control_head_ptr = REQ.wdata & `UHOR_PTR_MASK;
        end
        if (hit(REQ, `UHOR_OFS_CTRL_CUR)) begin
            next_control_cursor = REQ.wdata & `UHOR_PTR_MASK;
        end
        if (hit(REQ, `UHOR_OFS_BULK_HEAD)) begin
            next_bulk_head_ptr = REQ.wdata & `UHOR_PTR_MASK;
        end
        if (hit(REQ, `UHOR_OFS_BULK_CUR)) begin
            next_bulk_cursor = REQ.wdata & `UHOR_PTR_MASK;
        end
        if (hit(REQ, `UHOR_OFS_DONE_HEAD)) begin
            next_completed_head_ptr = REQ.wdata & `UHOR_PTR_MASK;
        end
        // list processor update of done head outranks software
        if (DONE_HEAD_LOAD) begin
            next_completed_head_ptr = DONE_HEAD_IN & `UHOR_PTR_MASK;
        end
        if (hit(REQ, `UHOR_OFS_FRAME_LEN)) begin
            next_frame_len = REQ.wdata & `UHOR_FRAME_LEN_MASK;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            comm_area_pointer  <= `UHOR_RST_ZERO;
            periodic_cursor    <= `UHOR_RST_ZERO;
            control_head_ptr   <= `UHOR_RST_ZERO;
            control_cursor     <= `UHOR_RST_ZERO;
            bulk_head_ptr      <= `UHOR_RST_ZERO;
            bulk_cursor        <= `UHOR_RST_ZERO;
            completed_head_ptr <= `UHOR_RST_ZERO;
            frame_len          <= `UHOR_RST_FRAME_LEN;
        end else begin
            comm_area_pointer  <= next_comm_area_pointer;
            periodic_cursor    <= next_periodic_cursor;
            control_head_ptr   <= next_control_head_ptr;
            control_cursor     <= next_control_cursor;
            bulk_head_ptr      <= next_bulk_head_ptr;
            bulk_cursor        <= next_bulk_cursor;
            completed_head_ptr <= next_completed_head_ptr;
            frame_len          <= next_frame_len;
        end
    end

    // read data, registered; unmapped addresses read zero
    always_comb begin
        next_rdata = `UHOR_RST_ZERO;
        if (REQ.sel && !REQ.wr) begin
            case (REQ.addr)
                `UHOR_OFS_CMD:        next_rdata = cmd;
                `UHOR_OFS_IRQ_FLAGS:  next_rdata = flags;
                `UHOR_OFS_IRQ_EN_SET: next_rdata = enables;
                `UHOR_OFS_IRQ_EN_CLR: next_rdata = enables;
                `UHOR_OFS_COMM_AREA:  next_rdata = comm_area_pointer;
                `UHOR_OFS_PERIODIC:   next_rdata = periodic_cursor;
                `UHOR_OFS_CTRL_HEAD:  next_rdata = control_head_ptr;
                `UHOR_OFS_CTRL_CUR:   next_rdata = control_cursor;
                `UHOR_OFS_BULK_HEAD:  next_rdata = bulk_head_ptr;
                `UHOR_OFS_BULK_CUR:   next_rdata = bulk_cursor;
                `UHOR_OFS_DONE_HEAD:  next_rdata = completed_head_ptr;
                `UHOR_OFS_FRAME_LEN:  next_rdata = frame_len;
                `UHOR_OFS_FRAME_NUM:  next_rdata = {16'h0000, frame_counter};
                default:              next_rdata = `UHOR_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= `UHOR_RST_ZERO;
        end else begin
            RDATA <= next_rdata;
        end
    end

    assign SOFT_RESET_REQ = cmd[`UHOR_BIT_SOFT_RESET];
    assign CTRL_PENDING   = cmd[`UHOR_BIT_CTRL_PEND];
    assign BULK_PENDING   = cmd[`UHOR_BIT_BULK_PEND];
    assign COMM_AREA      = comm_area_pointer;
    assign CTRL_HEAD      = control_head_ptr;
    assign BULK_HEAD      = bulk_head_ptr;
    assign FRAME_LEN      = frame_len;
    assign FRAME_NUMBER   = frame_counter;
    assign IRQ = enables[`UHOR_BIT_MASTER]
              && |(flags & enables & `UHOR_EVENT_MASK);

endmodule : uhor_regs

`default_nettype wire

// ===== verilog/uhor_cfg.svh
/*
 * Constants of the host controller operational register bank: offsets,
 * field positions, reset values.
 * Assumes inclusion by bare name from the package and the bench monitor.
 */
`ifndef UHOR_CFG_SVH
`define UHOR_CFG_SVH

`define UHOR_OFS_CMD        32'hFFF0_5008
`define UHOR_OFS_IRQ_FLAGS  32'hFFF0_500C
`define UHOR_OFS_IRQ_EN_SET 32'hFFF0_5010
`define UHOR_OFS_IRQ_EN_CLR 32'hFFF0_5014
`define UHOR_OFS_COMM_AREA  32'hFFF0_5018
`define UHOR_OFS_PERIODIC   32'hFFF0_501C
`define UHOR_OFS_CTRL_HEAD  32'hFFF0_5020
`define UHOR_OFS_CTRL_CUR   32'hFFF0_5024
`define UHOR_OFS_BULK_HEAD  32'hFFF0_5028
`define UHOR_OFS_BULK_CUR   32'hFFF0_502C
`define UHOR_OFS_DONE_HEAD  32'hFFF0_5030
`define UHOR_OFS_FRAME_LEN  32'hFFF0_5034
`define UHOR_OFS_FRAME_NUM  32'hFFF0_503C

`define UHOR_BIT_SOFT_RESET   0
`define UHOR_BIT_CTRL_PEND    1
`define UHOR_BIT_BULK_PEND    2
`define UHOR_BIT_OWNER_REQ    3
`define UHOR_CNT_LO           16
`define UHOR_CNT_HI           17

`define UHOR_BIT_OVERRUN      0
`define UHOR_BIT_DONE_WRITTEN 1
`define UHOR_BIT_FRAME_START  2
`define UHOR_BIT_RESUME       3
`define UHOR_BIT_FATAL        4
`define UHOR_BIT_FRAME_WRAP   5
`define UHOR_BIT_HUB_CHANGE   6
`define UHOR_BIT_OWNER_SWAP   30
`define UHOR_BIT_MASTER       31

`define UHOR_EVENT_MASK       32'h4000_006F
`define UHOR_ENABLE_MASK      32'hC000_006F
`define UHOR_COMM_AREA_MASK   32'hFFFF_FF00
`define UHOR_PTR_MASK         32'hFFFF_FFF0
`define UHOR_FRAME_LEN_MASK   32'hFFFF_3FFF
`define UHOR_RST_FRAME_LEN    32'h0000_2EDF
`define UHOR_RST_ZERO         32'h0000_0000
`define UHOR_FRAME_MSB        15

`endif

// ===== verilog/uhor_pkg.sv
/*
 * Types of the host controller operational register bank.
 * Assumes uhor_cfg.svh is on the include path.
 */
package uhor_pkg;
    `include "uhor_cfg.svh"

    // register port request from software
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } uhor_req_t;

    // internal events from list processor, frame logic and root hub
    typedef struct packed {
        logic overrun;
        logic done_written;
        logic frame_start;
        logic resume;
        logic hub_change;
        logic bulk_fill;
        logic bulk_begin;
        logic ctrl_fill;
        logic ctrl_begin;
        logic reset_done;
    } uhor_evt_t;

    typedef enum logic [0:0] {
        UHOR_IDLE  = 1'b0,
        UHOR_RESET = 1'b1
    } uhor_state_t;
endpackage : uhor_pkg

// ===== tb/uhor_regs_monitor.sv
/* port checker for uhor_regs.
   assumes a bind from tb_top and uhor_cfg.svh on the path. */
`timescale 1ns/1ps
`default_nettype none
`include "uhor_cfg.svh"
module uhor_monitor
    import uhor_pkg::*;
(
    input wire logic                SYS_CLK,
    input wire logic                RST_N,
    input wire uhor_pkg::uhor_req_t REQ,
    input wire logic [31:0]         RDATA,
    input wire uhor_pkg::uhor_evt_t EVT,
    input wire logic                FRAME_RELOAD,
    input wire logic [31:0]         DONE_HEAD_IN,
    input wire logic                DONE_HEAD_LOAD,
    input wire logic                SOFT_RESET_REQ,
    input wire logic                CTRL_PENDING,
    input wire logic                BULK_PENDING,
    input wire logic [31:0]         COMM_AREA,
    input wire logic [31:0]         CTRL_HEAD,
    input wire logic [31:0]         BULK_HEAD,
    input wire logic [31:0]         FRAME_LEN,
    input wire logic [15:0]         FRAME_NUMBER,
    input wire logic                IRQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    wire logic wc = REQ.sel && REQ.wr && REQ.addr == `UHOR_OFS_CMD;
    wire logic wr = REQ.sel && REQ.wr;
    chk_frame_step: assert property (
        FRAME_RELOAD |=> FRAME_NUMBER == $past(FRAME_NUMBER) + 16'h0001)
        else $error("frame counter did not step");
    chk_frame_hold: assert property (
        !FRAME_RELOAD |=> $stable(FRAME_NUMBER))
        else $error("frame counter moved without reload");
    chk_bulk_clear: assert property (
        EVT.bulk_begin && !EVT.bulk_fill && !wc |=> !BULK_PENDING)
        else $error("bulk pending not cleared");
    chk_ctrl_clear: assert property (
        EVT.ctrl_begin && !EVT.ctrl_fill && !wc |=> !CTRL_PENDING)
        else $error("control pending not cleared");
    chk_fill_set: assert property (
        EVT.bulk_fill && !wc |=> BULK_PENDING)
        else $error("bulk pending not set by device");
    chk_reset_done: assert property (
        EVT.reset_done && !wc |=> !SOFT_RESET_REQ)
        else $error("soft reset bit not cleared");
    chk_reset_stay: assert property (
        SOFT_RESET_REQ && !EVT.reset_done && !wc |=> SOFT_RESET_REQ)
        else $error("soft reset bit dropped early");
    chk_comm_mask: assert property (
        wr && REQ.addr == `UHOR_OFS_COMM_AREA
        |=> COMM_AREA == ($past(REQ.wdata) & 32'hFFFF_FF00))
        else $error("comm area base wrong");
    chk_head_mask: assert property (
        wr && REQ.addr == `UHOR_OFS_BULK_HEAD
        |=> BULK_HEAD == ($past(REQ.wdata) & 32'hFFFF_FFF0))
        else $error("bulk head pointer wrong");
    chk_ctrl_head: assert property (
        wr && REQ.addr == `UHOR_OFS_CTRL_HEAD
        |=> CTRL_HEAD == ($past(REQ.wdata) & 32'hFFFF_FFF0))
        else $error("control head pointer wrong");
    chk_frame_len: assert property (
        wr && REQ.addr == `UHOR_OFS_FRAME_LEN
        |=> FRAME_LEN == ($past(REQ.wdata) & 32'hFFFF_3FFF))
        else $error("frame length register wrong");
    chk_ctrl_fill: assert property (
        EVT.ctrl_fill && !wc |=> CTRL_PENDING)
        else $error("control pending not set by device");
endmodule : uhor_monitor
`default_nettype wire

// ===== tb/uhor_host.sv
/* software side model: single word register accesses.
   assumes the register port takes a request at the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module uhor_host
    import uhor_pkg::*;
(
    input  wire logic               SYS_CLK,
    input  wire logic [31:0]        RDATA,
    output var uhor_pkg::uhor_req_t REQ
);
    initial REQ = '0;
    // software writes one word to any register address, request held for one rising edge
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(negedge SYS_CLK);
        REQ = '{1'b1, 1'b1, a, d};
        @(negedge SYS_CLK);
        REQ = '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        @(negedge SYS_CLK);
        REQ = '{1'b1, 1'b0, a, 32'h5A5A_A5A5};
        @(negedge SYS_CLK);
        d = RDATA;
        REQ = '{1'b0, 1'b1, ~a, 32'hA5A5_5A5A};
    endtask : rd
endmodule : uhor_host
`default_nettype wire

// ===== tb/tb_top.sv
/* self-checking bench for uhor_regs.
   assumes uhor_pkg, uhor_host and uhor_monitor compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin \
    miscompares++; $display("Error %0t: got %h exp %h", $time, g, e); \
    end end
module tb_top;
    import uhor_pkg::*;
    localparam logic [31:0] B = 32'hFFF0_5000;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    uhor_req_t   req;
    uhor_evt_t   evt = '0;
    logic [31:0] rdata, rd, dh_in = '0;
    logic        reload = 1'b0, dh_load = 1'b0, srst, cpend, bpend, irq;
    logic [15:0] fnum;
    logic [9:0]  ev[5] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020};
    int          fb[5] = '{1, 2, 4, 8, 64};
    int          miscompares = 0, n_checks = 0, cycles = 0;
    int          flags = 0, en = 0, seed = 32'hA2D8, i, d;
    uhor_host host_u (.SYS_CLK(clk), .RDATA(rdata), .REQ(req));
    uhor_regs dut_u (.SYS_CLK(clk), .RST_N(rst_n), .REQ(req),
        .RDATA(rdata), .EVT(evt), .FRAME_RELOAD(reload),
        .DONE_HEAD_IN(dh_in), .DONE_HEAD_LOAD(dh_load),
        .SOFT_RESET_REQ(srst), .CTRL_PENDING(cpend), .BULK_PENDING(bpend),
        .COMM_AREA(), .CTRL_HEAD(), .BULK_HEAD(), .FRAME_LEN(),
        .FRAME_NUMBER(fnum), .IRQ(irq));
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        if (miscompares == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish
    task automatic pulse(input logic [9:0] v);
        @(negedge clk);
        evt = uhor_evt_t'(v);
        @(negedge clk);
        evt = '0;
    endtask : pulse
    task automatic rchk(input int o, input int e);
        host_u.rd(B + 32'(o), rd);
        `CHK(rd, 32'(e))
    endtask : rchk
    task automatic irqchk();
        `CHK(irq, 1'(en[31] && (flags & en & 32'h4000_006F) != 0))
    endtask : irqchk
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        rchk(8'h00, 0);
        for (i = 0; i < 14; i++)
            rchk(8 + 4 * i, i == 11 ? 32'h2EDF : 0);
        for (i = 4; i < 12; i++) begin
            d = $random(seed);
            host_u.wr(B + 32'(8 + 4 * i), d);
            rchk(8 + 4 * i, d & (i == 4 ? 32'hFFFF_FF00 :
                i == 11 ? 32'hFFFF_3FFF : 32'hFFFF_FFF0));
        end
        host_u.wr(B + 32'h10, 32'hFFFF_FFFF);
        en = 32'hC000_006F;
        host_u.wr(B + 32'h14, 32'h10);
        rchk(8'h14, en);
        irqchk();
        for (i = 0; i < 5; i++) begin
            pulse(ev[i]);
            flags |= fb[i];
            irqchk();
            rchk(8'h0C, flags);
            host_u.wr(B + 32'h14, fb[i]);
            en &= ~fb[i];
            irqchk();
            host_u.wr(B + 32'h10, fb[i]);
            en |= fb[i];
            host_u.wr(B + 32'h0C, 32'h0);
            rchk(8'h0C, flags);
            host_u.wr(B + 32'h0C, fb[i] | 32'h10);
            flags = 0;
            rchk(8'h0C, flags);
        end
        repeat (4) pulse(10'h200);
        rchk(8'h08, 32'h0001_0000);
        host_u.wr(B + 32'h0C, 32'h1);
        host_u.wr(B + 32'h08, 32'h0001_0008);
        rchk(8'h08, 32'h0001_0008);
        rchk(8'h0C, 32'h4000_0000);
        host_u.wr(B + 32'h08, 32'h0001_0000);
        host_u.wr(B + 32'h0C, 32'h4000_0000);
        flags = 8;
        pulse(10'h040);
        host_u.wr(B + 32'h14, 32'h8000_0000);
        en = 32'h4000_006F;
        irqchk();
        rchk(8'h10, en);
        host_u.wr(B + 32'h0C, 32'h8);
        host_u.wr(B + 32'h08, 32'h0001_0006);
        `CHK({bpend, cpend}, 2'b11)
        pulse(10'h008);
        `CHK({bpend, cpend}, 2'b01)
        pulse(10'h002);
        `CHK({bpend, cpend}, 2'b00)
        pulse(10'h014);
        `CHK({bpend, cpend}, 2'b11)
        host_u.wr(B + 32'h08, 32'h0001_0001);
        `CHK({srst, bpend, cpend}, 3'b100)
        pulse(10'h001);
        `CHK(srst, 1'b0)
        @(negedge clk);
        reload = 1'b1;
        repeat (32768) @(negedge clk);
        reload = 1'b0;
        `CHK(fnum, 16'h8000)
        rchk(8'h0C, 32'h20);
        d = $random(seed);
        @(negedge clk);
        dh_in = d;
        dh_load = 1'b1;
        @(negedge clk);
        dh_load = 1'b0;
        rchk(8'h30, d & 32'hFFFF_FFF0);
        tally_and_finish();
    end
endmodule : tb_top
bind uhor_regs uhor_monitor mon_u (.*);
`default_nettype wire
